// ===== verilog/tdm_timers.sv
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/10ps
`include "tdm_params.svh"
module tdm_timers
  import tdm_pkg::*;
#(
  parameter int SYS_DIV  = `TDM_SYS_DIV,
  parameter int SLOW_DIV = `TDM_SLOW_DIV,
  parameter int AUX_DIV  = `TDM_AUX_DIV
) (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       gate0_input_pin_i,
  input  wire logic       gate1_input_pin_i,
  input  wire logic       event0_input_pin_i,
  input  wire logic       event1_input_pin_i,
  input  wire logic       slow_clock_source_i,
  input  wire logic       aux_frequency_input_i,
  output logic            timer0_overflow_o,
  output logic            timer1_overflow_flag_o,
  output logic            irq_o
);

  // returns {overflow, high, low} after one count step
  function automatic logic [16:0] tdm_count_step(
    input tdm_mode_t  mode,
    input logic [7:0] low,
    input logic [7:0] high,
    input logic       inc
  );
    logic [16:0] res;
    res = {1'b0, high, low};
    if (inc) begin
      case (mode)
        TDM_MODE_PRESCALE: begin
          if (low[4:0] == 5'h1f) begin
            res[4:0]  = 5'h00;
            res[16:8] = {1'b0, high} + 9'h001;
          end else begin
            res[4:0] = low[4:0] + 5'h01;
          end
        end
        TDM_MODE_WIDE: begin
          res = {1'b0, high, low} + 17'h00001;
        end
        TDM_MODE_RELOAD: begin
          if (low == 8'hff) begin
            res = {1'b1, high, high};
          end else begin
            res[7:0] = low + 8'h01;
          end
        end
        default: begin
          res = {1'b0, high, low};
        end
      endcase
    end
    return res;
  endfunction

  logic gate0_lvl;
  logic gate1_lvl;
  logic event0_fall;
  logic event1_fall;
  logic slow_fall;
  logic aux_fall;
  logic sys_tick;
  logic slow_tick;
  logic aux_tick;

  tdm_sync_fall u_gate0 (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .pin_i     (gate0_input_pin_i),
    .level_o   (gate0_lvl),
    .fall_o    ()
  );

  tdm_sync_fall u_gate1 (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .pin_i     (gate1_input_pin_i),
    .level_o   (gate1_lvl),
    .fall_o    ()
  );

  tdm_sync_fall u_event0 (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .pin_i     (event0_input_pin_i),
    .level_o   (),
    .fall_o    (event0_fall)
  );

  tdm_sync_fall u_event1 (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .pin_i     (event1_input_pin_i),
    .level_o   (),
    .fall_o    (event1_fall)
  );

  tdm_sync_fall u_slow (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .pin_i     (slow_clock_source_i),
    .level_o   (),
    .fall_o    (slow_fall)
  );

  tdm_sync_fall u_aux (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .pin_i     (aux_frequency_input_i),
    .level_o   (),
    .fall_o    (aux_fall)
  );

  // shared prescale for timer mode
  tdm_div #(.DIV(SYS_DIV)) u_sys_div (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .pulse_i   (1'b1),
    .tick_o    (sys_tick)
  );

  // one tick per falling edge of the divided slow clock
  tdm_div #(.DIV(SLOW_DIV)) u_slow_div (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .pulse_i   (slow_fall),
    .tick_o    (slow_tick)
  );

  tdm_div #(.DIV(AUX_DIV)) u_aux_div (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .pulse_i   (aux_fall),
    .tick_o    (aux_tick)
  );

  logic [7:0] mode_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] tl0_reg;
  logic [7:0] th0_reg;
  logic [7:0] tl1_reg;
  logic [7:0] th1_reg;
  logic [1:0] stat_reg;
  logic [1:0] mask_reg;
  logic [7:0] rdata_reg;
  logic       ovf0_reg;

  logic       wr_mode;
  logic       wr_ctrl;
  logic       wr_tl0;
  logic       wr_th0;
  logic       wr_tl1;
  logic       wr_th1;
  logic       wr_stat;
  logic       wr_mask;

  assign wr_mode = wr_i && (addr_i == `TDM_ADDR_MODE);
  assign wr_ctrl = wr_i && (addr_i == `TDM_ADDR_CTRL);
  assign wr_tl0  = wr_i && (addr_i == `TDM_ADDR_TL0);
  assign wr_th0  = wr_i && (addr_i == `TDM_ADDR_TH0);
  assign wr_tl1  = wr_i && (addr_i == `TDM_ADDR_TL1);
  assign wr_th1  = wr_i && (addr_i == `TDM_ADDR_TH1);
  assign wr_stat = wr_i && (addr_i == `TDM_ADDR_STAT);
  assign wr_mask = wr_i && (addr_i == `TDM_ADDR_MASK);

  tdm_mode_t mode0;
  tdm_mode_t mode1;
  tdm_src_t  src0;
  logic      gate0_en;
  logic      gate1_en;
  logic      sel0_counter;
  logic      sel1_counter;
  logic      run0_bit;
  logic      run1_bit;
  logic      src1_slow;

  assign mode0        = tdm_mode_t'(mode_reg[`TDM_M_MODE0_HI:`TDM_M_MODE0_LO]);
  assign mode1        = tdm_mode_t'(mode_reg[`TDM_M_MODE1_HI:`TDM_M_MODE1_LO]);
  assign gate0_en     = mode_reg[`TDM_M_GATE0];
  assign gate1_en     = mode_reg[`TDM_M_GATE1];
  assign sel0_counter = mode_reg[`TDM_M_SEL0];
  assign sel1_counter = mode_reg[`TDM_M_SEL1];
  assign run0_bit     = ctrl_reg[`TDM_C_RUN0];
  assign run1_bit     = ctrl_reg[`TDM_C_RUN1];
  assign src0         = tdm_src_t'(ctrl_reg[`TDM_C_SRC0_HI:`TDM_C_SRC0_LO]);
  assign src1_slow    = ctrl_reg[`TDM_C_SRC1];

  logic run0;
  logic run1;
  logic evt0;
  logic evt1;
  logic inc0;
  logic inc1;

  assign run0 = run0_bit & (~gate0_en | gate0_lvl);
  assign run1 = run1_bit & (~gate1_en | gate1_lvl);

  always_comb begin
    case (src0)
      TDM_SRC_PIN:  evt0 = event0_fall;
      TDM_SRC_SLOW: evt0 = slow_tick;
      TDM_SRC_AUX:  evt0 = aux_tick;
      default:      evt0 = 1'b0;
    endcase
  end

  assign evt1 = src1_slow ? slow_tick : event1_fall;

  assign inc0 = run0 & (sel0_counter ? evt0 : sys_tick);
  assign inc1 = run1 & (sel1_counter ? evt1 : sys_tick);

  logic [16:0] step0;
  logic [16:0] step1;

  assign step0 = tdm_count_step(mode0, tl0_reg, th0_reg, inc0);
  assign step1 = tdm_count_step(mode1, tl1_reg, th1_reg, inc1);

  logic [7:0] tl0_next;
  logic [7:0] th0_next;
  logic [7:0] tl1_next;
  logic [7:0] th1_next;
  logic [1:0] stat_next;

  // software writes win over the count step in the same cycle
  always_comb begin
    tl0_next = wr_tl0 ? wdata_i : step0[7:0];
    th0_next = wr_th0 ? wdata_i : step0[15:8];
    tl1_next = wr_tl1 ? wdata_i : step1[7:0];
    th1_next = wr_th1 ? wdata_i : step1[15:8];
  end

  // write one to clear; a new overflow in the same cycle wins
  always_comb begin
    stat_next = stat_reg;
    if (wr_stat) begin
      stat_next = stat_reg & ~wdata_i[1:0];
    end
    stat_next[`TDM_S_OVF0] = stat_next[`TDM_S_OVF0] | step0[16];
    stat_next[`TDM_S_OVF1] = stat_next[`TDM_S_OVF1] | step1[16];
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      mode_reg <= `TDM_MODE_RST;
      ctrl_reg <= `TDM_CTRL_RST;
    end else begin
      if (wr_mode) begin
        mode_reg <= wdata_i;
      end
      if (wr_ctrl) begin
        ctrl_reg <= wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      tl0_reg <= `TDM_DATA_RST;
      th0_reg <= `TDM_DATA_RST;
    end else begin
      tl0_reg <= tl0_next;
      th0_reg <= th0_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      tl1_reg <= `TDM_DATA_RST;
      th1_reg <= `TDM_DATA_RST;
    end else begin
      tl1_reg <= tl1_next;
      th1_reg <= th1_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      stat_reg <= `TDM_STAT_RST;
      mask_reg <= `TDM_MASK_RST;
      ovf0_reg <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      ovf0_reg <= step0[16];
      if (wr_mask) begin
        mask_reg <= wdata_i[1:0];
      end
    end
  end

  // read data stands for the one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata_reg <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `TDM_ADDR_CTRL: rdata_reg <= ctrl_reg;
        `TDM_ADDR_MODE: rdata_reg <= mode_reg;
        `TDM_ADDR_TL0:  rdata_reg <= tl0_reg;
        `TDM_ADDR_TH0:  rdata_reg <= th0_reg;
        `TDM_ADDR_TL1:  rdata_reg <= tl1_reg;
        `TDM_ADDR_TH1:  rdata_reg <= th1_reg;
        `TDM_ADDR_STAT: rdata_reg <= {6'h00, stat_reg};
        `TDM_ADDR_MASK: rdata_reg <= {6'h00, mask_reg};
        default:        rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign rdata_o                = rdata_reg;
  assign timer0_overflow_o      = ovf0_reg;
  assign timer1_overflow_flag_o = stat_reg[`TDM_S_OVF1];
  assign irq_o                  = |(stat_reg & mask_reg);

endmodule

// ===== verilog/tdm_params.svh
// How it works
// - with timer1 gating clear, timer1 counts whenever its run bit is set and its mode is not stop (mode 3), whatever the gate pin does.
// - with timer1 gating set, timer1 counts only while its gate pin is high and its run bit is set.
// - with timer0 gating clear, timer0 counts whenever its run bit is set, except in stop mode (mode 3), where it holds.
// - with timer0 gating set, timer0 counts only while its gate pin is high and its run bit is set.
// - in timer mode, timer1 advances once every 2 system clock cycles.
// - in timer mode, timer0 advances once every 2 system clock cycles.
// - in counter mode, timer1 advances on each falling edge of its event pin or of the slow clock divided by 16.
// - in counter mode, timer0 advances on each falling edge of its event pin, the slow clock divided by 16 or the divided aux input.
// - in the prescaled mode the high byte counts, fed by a 5-bit prescaler in the low byte.
// - in auto-reload mode timer1 counts in its low byte and reloads it from the high byte in the overflow cycle.
// - in auto-reload mode timer0 counts in its low byte and reloads it from the high byte on each overflow.
// - timer0 low and high bytes are read/write at 8Ah and 8Ch and reset to zero.
`ifndef TDM_PARAMS_SVH
`define TDM_PARAMS_SVH

`define TDM_ADDR_CTRL    8'h88
`define TDM_ADDR_MODE    8'h89
`define TDM_ADDR_TL0     8'h8a
`define TDM_ADDR_TL1     8'h8b
`define TDM_ADDR_TH0     8'h8c
`define TDM_ADDR_TH1     8'h8d
`define TDM_ADDR_STAT    8'h90
`define TDM_ADDR_MASK    8'h91

`define TDM_MODE_RST     8'h00
`define TDM_CTRL_RST     8'h00
`define TDM_DATA_RST     8'h00
`define TDM_STAT_RST     2'h0
`define TDM_MASK_RST     2'h0

// mode register fields
`define TDM_M_GATE1      7
`define TDM_M_SEL1       6
`define TDM_M_MODE1_HI   5
`define TDM_M_MODE1_LO   4
`define TDM_M_GATE0      3
`define TDM_M_SEL0       2
`define TDM_M_MODE0_HI   1
`define TDM_M_MODE0_LO   0

// control register fields
`define TDM_C_RUN0       0
`define TDM_C_RUN1       1
`define TDM_C_SRC0_LO    2
`define TDM_C_SRC0_HI    3
`define TDM_C_SRC1       4

// status and mask fields
`define TDM_S_OVF0       0
`define TDM_S_OVF1       1

`define TDM_SYS_DIV      2
`define TDM_SLOW_DIV     16
`define TDM_AUX_DIV      4

`endif

// ===== verilog/tdm_pkg.sv
package tdm_pkg;

  typedef enum logic [1:0] {
    TDM_MODE_PRESCALE = 2'h0,
    TDM_MODE_WIDE     = 2'h1,
    TDM_MODE_RELOAD   = 2'h2,
    TDM_MODE_STOP     = 2'h3
  } tdm_mode_t;

  typedef enum logic [1:0] {
    TDM_SRC_PIN  = 2'h0,
    TDM_SRC_SLOW = 2'h1,
    TDM_SRC_AUX  = 2'h2
  } tdm_src_t;

endpackage

// ===== verilog/tdm_sync_fall.sv
`timescale 1ns/10ps
module tdm_sync_fall (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      fall_o
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level_o = sync_reg;
  assign fall_o  = prev_reg & ~sync_reg;
endmodule

// ===== verilog/tdm_div.sv
`timescale 1ns/10ps
module tdm_div #(
  parameter int DIV = 2
) (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic pulse_i,
  output logic      tick_o
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  logic [CW-1:0] cnt_reg;
  logic          last;

  assign last   = (cnt_reg == CW'(DIV - 1));
  assign tick_o = pulse_i & last;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cnt_reg <= '0;
    end else if (pulse_i) begin
      cnt_reg <= last ? '0 : cnt_reg + CW'(1);
    end
  end
endmodule

// ===== tb/tdm_timers_assertions.sv
`timescale 1ns/10ps
module tdm_chk (
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       gate0_input_pin_i,
  input wire logic       gate1_input_pin_i,
  input wire logic       timer0_overflow_o,
  input wire logic       timer1_overflow_flag_o,
  input wire logic       irq_o
);
  logic [7:0] mode_reg;
  logic [7:0] ctrl_reg;
  logic [1:0] mask_reg;
  logic [3:0] q0_reg;
  logic [3:0] q1_reg;
  logic [3:0] s1_reg;
  logic       idle0;
  logic       idle1;
  logic       clr1;
  // mirrors of the software-set registers
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      mode_reg <= 8'h00;
      ctrl_reg <= 8'h00;
      mask_reg <= 2'h0;
    end else if (wr_i) begin
      if (addr_i == 8'h89) mode_reg <= wdata_i;
      if (addr_i == 8'h88) ctrl_reg <= wdata_i;
      if (addr_i == 8'h91) mask_reg <= wdata_i[1:0];
    end
  end
  assign clr1  = wr_i && addr_i == 8'h90 && wdata_i[1];
  assign idle0 = !ctrl_reg[0] || (mode_reg[3] && !gate0_input_pin_i) || mode_reg[1:0] == 2'h3;
  assign idle1 = !ctrl_reg[1] || (mode_reg[7] && !gate1_input_pin_i);
  // saturating counts of cycles spent halted
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      q0_reg <= 4'h0;
      q1_reg <= 4'h0;
      s1_reg <= 4'h0;
    end else begin
      q0_reg <= !idle0 ? 4'h0 : q0_reg + {3'h0, q0_reg != 4'hf};
      q1_reg <= !idle1 ? 4'h0 : q1_reg + {3'h0, q1_reg != 4'hf};
      s1_reg <= mode_reg[5:4] != 2'h3 ? 4'h0 : s1_reg + {3'h0, s1_reg != 4'hf};
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  idle0_quiet_a: assert property (q0_reg >= 4'h8 |-> !timer0_overflow_o)
    else $error("timer0 overflow while halted");
  idle1_quiet_a: assert property (q1_reg >= 4'h8 |-> !$rose(timer1_overflow_flag_o))
    else $error("timer1 overflow while halted");
  stop_hold_a: assert property (s1_reg >= 4'h8 |-> !$rose(timer1_overflow_flag_o))
    else $error("timer1 overflow in stop mode");
  ovf_pulse_a: assert property (timer0_overflow_o |=> !timer0_overflow_o)
    else $error("timer0 overflow pulse too long");
  flag_sticky_a: assert property (timer1_overflow_flag_o && !clr1 && !$past(clr1) |=> timer1_overflow_flag_o)
    else $error("timer1 flag lost");
  irq_raise_a: assert property (mask_reg[1] && timer1_overflow_flag_o && !$past(clr1) |-> irq_o)
    else $error("irq missing");
  irq_masked_a: assert property (mask_reg == 2'h0 |-> !irq_o)
    else $error("irq while masked");
  rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data without read");
  cover property (timer0_overflow_o);
  cover property ($rose(timer1_overflow_flag_o));
  cover property (irq_o && rd_i);
endmodule
bind tdm_timers tdm_chk i_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .gate0_input_pin_i(gate0_input_pin_i),
  .gate1_input_pin_i(gate1_input_pin_i), .timer0_overflow_o(timer0_overflow_o),
  .timer1_overflow_flag_o(timer1_overflow_flag_o), .irq_o(irq_o));

// ===== tb/tdm_pin_model.sv
`timescale 1ns/10ps
module tdm_pin_model (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] n_i,
  output logic            busy_o,
  output logic            ev_o
);
  logic [7:0] left_reg = 8'h00;
  logic [2:0] ph_reg = 3'h0;
  logic       ev_reg = 1'b1;
  assign busy_o = left_reg != 8'h00;
  assign ev_o   = ev_reg;
  // n falling edges, each low 4 cycles, slow enough for the pin synchronisers
  always_ff @(posedge clk_i) begin
    if (go_i && !busy_o) begin
      left_reg <= n_i;
      ph_reg   <= 3'h0;
    end else if (busy_o) begin
      ph_reg <= ph_reg + 3'h1;
      ev_reg <= ph_reg < 3'h3 || ph_reg == 3'h7;
      if (ph_reg == 3'h7) left_reg <= left_reg - 8'h01;
    end
  end
endmodule

// ===== tb/tb.sv
`timescale 1ns/10ps
module tb;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       g0 = 1'b0;
  logic       g1 = 1'b0;
  logic       go = 1'b0;
  logic [7:0] n = 8'h00;
  logic [7:0] rdata;
  logic       ev;
  logic       busy;
  logic       ovf0;
  logic       flag1;
  logic       irq;
  int         bad_count = 0;
  int         checks_done = 0;
  int         ovf0_pulses = 0;
  always #5 clk = ~clk;
  // count overflow pulses mid-cycle, where the output has settled
  always @(negedge clk) begin
    if (ovf0 === 1'b1) ovf0_pulses++;
  end
  tdm_timers i_dut (.clk_i(clk), .reset_n_i(reset_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .gate0_input_pin_i(g0), .gate1_input_pin_i(g1), .event0_input_pin_i(ev),
    .event1_input_pin_i(ev), .slow_clock_source_i(ev), .aux_frequency_input_i(ev),
    .timer0_overflow_o(ovf0), .timer1_overflow_flag_o(flag1), .irq_o(irq));
  tdm_pin_model i_pins (.clk_i(clk), .go_i(go), .n_i(n), .busy_o(busy), .ev_o(ev));
  task automatic chk(input string s, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] got);
    checks_done++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      $display("ERROR %s expected %h..%h seen %h", s, lo, hi, got);
      bad_count++;
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rc(input string s, input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(s, lo, hi, rdata);
  endtask
  task automatic run(input logic [7:0] c, input int cyc);
    wreg(8'h88, c);
    repeat (cyc) @(posedge clk);
    wreg(8'h88, 8'h00);
  endtask
  task automatic burst(input logic [7:0] cnt);
    int k;
    @(posedge clk);
    n  <= cnt;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    #1;
    for (k = 0; k < 2000 && busy; k++) @(posedge clk);
    repeat (8) @(posedge clk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    tally_and_finish;
  end
  initial begin
    logic [7:0] t;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rc("tl0 reset", 8'h8a, 8'h00, 8'h00);
    rc("th0 reset", 8'h8c, 8'h00, 8'h00);
    wreg(8'h8a, 8'ha5);
    wreg(8'h8c, 8'h3c);
    rc("tl0", 8'h8a, 8'ha5, 8'ha5);
    rc("th0", 8'h8c, 8'h3c, 8'h3c);
    rc("unmapped", 8'h80, 8'h00, 8'h00);
    wreg(8'h91, 8'h03);
    for (t = 8'h00; t < 8'h02; t++) begin
      wreg(8'h89, t[0] ? 8'h20 : 8'h02);
      wreg(8'h8c + t, 8'h00);
      wreg(8'h8a + t, 8'h00);
      run(8'h01 << t, 38);
      rc("rate", 8'h8a + t, 8'h13, 8'h15);
      wreg(8'h8c + t, 8'h5a);
      wreg(8'h8a + t, 8'hff);
      run(8'h01 << t, 2);
      rc("reload", 8'h8a + t, 8'h5a, 8'h5c);
      rc("status", 8'h90, 8'h01 << t, 8'h01 << t);
      chk("irq", 8'h01, 8'h01, {7'h00, irq});
      chk("flag1", t, t, {7'h00, flag1});
      wreg(8'h90, 8'h01 << t);
      rc("status clr", 8'h90, 8'h00, 8'h00);
      chk("irq clr", 8'h00, 8'h00, {7'h00, irq});
      wreg(8'h89, 8'h00);
      wreg(8'h8c + t, 8'h00);
      wreg(8'h8a + t, 8'h00);
      run(8'h01 << t, 68);
      rc("prescale high", 8'h8c + t, 8'h01, 8'h01);
      rc("prescale low", 8'h8a + t, 8'h02, 8'h04);
    end
    wreg(8'h89, 8'h01);
    wreg(8'h8c, 8'hff);
    wreg(8'h8a, 8'hff);
    run(8'h01, 2);
    rc("wide low", 8'h8a, 8'h01, 8'h01);
    rc("wide high", 8'h8c, 8'h00, 8'h00);
    rc("wide ovf", 8'h90, 8'h01, 8'h01);
    wreg(8'h90, 8'h01);
    wreg(8'h89, 8'h33);
    wreg(8'h8a, 8'hff);
    wreg(8'h8b, 8'hff);
    run(8'h03, 38);
    rc("stop t0", 8'h8a, 8'hff, 8'hff);
    rc("stop t1", 8'h8b, 8'hff, 8'hff);
    rc("stop ovf", 8'h90, 8'h00, 8'h00);
    wreg(8'h8a, 8'h00);
    wreg(8'h8b, 8'h00);
    wreg(8'h89, 8'hee);
    wreg(8'h88, 8'h03);
    burst(8'd5);
    rc("gated t0", 8'h8a, 8'h00, 8'h00);
    rc("gated t1", 8'h8b, 8'h00, 8'h00);
    @(posedge clk);
    g0 <= 1'b1;
    g1 <= 1'b1;
    burst(8'd5);
    rc("open t0", 8'h8a, 8'h05, 8'h05);
    rc("open t1", 8'h8b, 8'h05, 8'h05);
    @(posedge clk);
    g0 <= 1'b0;
    g1 <= 1'b0;
    wreg(8'h89, 8'h66);
    burst(8'd3);
    rc("ungated t0", 8'h8a, 8'h08, 8'h08);
    rc("ungated t1", 8'h8b, 8'h08, 8'h08);
    wreg(8'h88, 8'h17);
    burst(8'd16);
    rc("slow t0", 8'h8a, 8'h09, 8'h09);
    rc("slow t1", 8'h8b, 8'h09, 8'h09);
    wreg(8'h88, 8'h0b);
    burst(8'd4);
    rc("aux t0", 8'h8a, 8'h0a, 8'h0a);
    rc("pin t1", 8'h8b, 8'h0d, 8'h0d);
    chk("ovf0 pulses", 8'h02, 8'h02, 8'(ovf0_pulses));
    tally_and_finish;
  end
endmodule
